// file: design/waveform_update_timing.sv
`timescale 1ns/1ps
module waveform_update_timing #(
    parameter int PFI_COUNT = 10
) (
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [wave_timing_pkg::ADDR_W-1:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Programmable input pins
    input wire logic [PFI_COUNT-1:0] pfi_i,
    // Buffer counter end of waveform
    input wire logic buffer_done_i,
    // Dedicated output pins
    output logic trig_pin_o,
    output logic trig_pin_oe_o,
    output logic strobe_pin_o,
    output logic strobe_pin_oe_o,
    // Converter side
    output logic wave_start_o,
    output logic dac_update_o
);

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    function automatic logic pick(input logic [PFI_COUNT-1:0] v,
                                  input logic [wave_timing_pkg::SEL_FIELD_W-1:0] idx);
        pick = (32'(idx) < PFI_COUNT) ? v[idx] : 1'b0;
    endfunction : pick

    function automatic logic edge_seen(input logic cur, input logic prev, input logic falling);
        edge_seen = falling ? (prev & ~cur) : (cur & ~prev);
    endfunction : edge_seen

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] sel, input logic [31:0] mask);
        logic [31:0] res;
        res = old;
        for (int b = 0; b < 4; b++) begin
            if (sel[b]) begin
                res[8*b +: 8] = val[8*b +: 8];
            end
        end
        merge = res & mask;
    endfunction : merge

    ////////////////////////////////////////////////////////////////////////////
    // Register bus

    wave_timing_pkg::ctrl_t ctrl_reg;
    logic [31:0] sel_reg;
    logic [31:0] load_reg;
    logic ack_reg;
    logic [31:0] rdata_reg;
    logic stop_cmd;
    logic swtrig_cmd;
    logic wr_now;
    wave_timing_pkg::status_t status;
    wave_timing_pkg::ui_state_t ui_state_reg;
    logic [wave_timing_pkg::LOAD_W-1:0] count_reg;
    logic gen_active_reg;

    // Writes land at the edge where the master sees ack
    assign wr_now = wb_cyc_i & wb_stb_i & wb_we_i & ack_reg;
    assign stop_cmd = wr_now & (wb_adr_i == wave_timing_pkg::ADDR_CMD)
        & wb_sel_i[0] & wb_dat_i[wave_timing_pkg::CMD_STOP_BIT];
    assign swtrig_cmd = wr_now & (wb_adr_i == wave_timing_pkg::ADDR_CMD)
        & wb_sel_i[0] & wb_dat_i[wave_timing_pkg::CMD_SWTRIG_BIT];
    assign wb_ack_o = ack_reg;
    assign wb_dat_o = rdata_reg;

    always_comb begin
        status = '0;
        status.count = count_reg;
        status.counting = (ui_state_reg == wave_timing_pkg::UI_RUN);
        status.generating = gen_active_reg;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_reg <= 1'b0;
        end else begin
            ack_reg <= wb_cyc_i & wb_stb_i & ~ack_reg;
        end
    end

    // Unmapped addresses read as zero and ignore writes
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rdata_reg <= 32'h0000_0000;
        end else if (wb_cyc_i & wb_stb_i & ~ack_reg) begin
            case (wb_adr_i)
                wave_timing_pkg::ADDR_CTRL: rdata_reg <= ctrl_reg;
                wave_timing_pkg::ADDR_SEL: rdata_reg <= sel_reg;
                wave_timing_pkg::ADDR_LOAD: rdata_reg <= load_reg;
                wave_timing_pkg::ADDR_STATUS: rdata_reg <= status;
                default: rdata_reg <= 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ctrl_reg <= wave_timing_pkg::CTRL_RESET;
            sel_reg <= wave_timing_pkg::SEL_RESET;
            load_reg <= wave_timing_pkg::LOAD_RESET;
        end else if (wr_now) begin
            if (wb_adr_i == wave_timing_pkg::ADDR_CTRL) begin
                ctrl_reg <= merge(ctrl_reg, wb_dat_i, wb_sel_i, wave_timing_pkg::CTRL_MASK);
            end
            if (wb_adr_i == wave_timing_pkg::ADDR_SEL) begin
                sel_reg <= merge(sel_reg, wb_dat_i, wb_sel_i, wave_timing_pkg::SEL_MASK);
            end
            if (wb_adr_i == wave_timing_pkg::ADDR_LOAD) begin
                load_reg <= merge(load_reg, wb_dat_i, wb_sel_i, wave_timing_pkg::LOAD_MASK);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Input synchronisation and edge detection

    logic [PFI_COUNT-1:0] pfi_meta_reg;
    logic [PFI_COUNT-1:0] pfi_sync_reg;
    logic [PFI_COUNT-1:0] pfi_prev_reg;
    logic [wave_timing_pkg::SEL_FIELD_W-1:0] trig_sel;
    logic [wave_timing_pkg::SEL_FIELD_W-1:0] strobe_sel;
    logic [wave_timing_pkg::SEL_FIELD_W-1:0] uiclk_sel;
    logic trig_edge;
    logic ext_strobe_edge;
    logic uiclk_lvl;
    logic uiclk_lvl_prev;
    logic ext_tick;

    // Meta stage feeds only the second stage
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pfi_meta_reg <= '0;
            pfi_sync_reg <= '0;
            pfi_prev_reg <= '0;
        end else begin
            pfi_meta_reg <= pfi_i;
            pfi_sync_reg <= pfi_meta_reg;
            pfi_prev_reg <= pfi_sync_reg;
        end
    end

    assign trig_sel = sel_reg[wave_timing_pkg::SEL_TRIG_LSB +: wave_timing_pkg::SEL_FIELD_W];
    assign strobe_sel = sel_reg[wave_timing_pkg::SEL_STROBE_LSB +: wave_timing_pkg::SEL_FIELD_W];
    assign uiclk_sel = sel_reg[wave_timing_pkg::SEL_UICLK_LSB +: wave_timing_pkg::SEL_FIELD_W];

    assign trig_edge = edge_seen(pick(pfi_sync_reg, trig_sel), pick(pfi_prev_reg, trig_sel),
                                 ctrl_reg.trig_falling);
    assign ext_strobe_edge = edge_seen(pick(pfi_sync_reg, strobe_sel),
                                       pick(pfi_prev_reg, strobe_sel),
                                       ctrl_reg.strobe_falling);
    // Level mode: polarity folded in, then each start of the active level is one count.
    // Pulses shorter than a clock period may be missed at the upper rate.
    assign uiclk_lvl = pick(pfi_sync_reg, uiclk_sel) ^ ctrl_reg.uiclk_active_low;
    assign uiclk_lvl_prev = pick(pfi_prev_reg, uiclk_sel) ^ ctrl_reg.uiclk_active_low;
    assign ext_tick = uiclk_lvl & ~uiclk_lvl_prev;

    ////////////////////////////////////////////////////////////////////////////
    // Update interval clock

    logic [wave_timing_pkg::SLOW_DIV_W-1:0] div_cnt_reg;
    logic slow_tick;
    logic ui_tick;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            div_cnt_reg <= '0;
        end else if (slow_tick) begin
            div_cnt_reg <= '0;
        end else begin
            div_cnt_reg <= div_cnt_reg + 1'b1;
        end
    end

    assign slow_tick = (div_cnt_reg ==
        wave_timing_pkg::SLOW_DIV_W'(wave_timing_pkg::SLOW_TB_DIV - 1));

    // Reserved source code falls back to the fast timebase
    always_comb begin
        case (ctrl_reg.ui_src)
            wave_timing_pkg::UICLK_SLOW: ui_tick = slow_tick;
            wave_timing_pkg::UICLK_EXT: ui_tick = ext_tick;
            default: ui_tick = 1'b1;
        endcase
    end

    ////////////////////////////////////////////////////////////////////////////
    // Trigger and interval counter

    logic trig_fire;
    logic ui_stop;
    logic int_strobe_reg;

    assign trig_fire = ctrl_reg.arm & (trig_edge | swtrig_cmd);
    assign ui_stop = stop_cmd | buffer_done_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            gen_active_reg <= 1'b0;
            wave_start_o <= 1'b0;
        end else begin
            wave_start_o <= trig_fire;
            if (trig_fire) begin
                gen_active_reg <= 1'b1;
            end else if (ui_stop) begin
                gen_active_reg <= 1'b0;
            end
        end
    end

    // Stop wins over a trigger arriving in the same cycle
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ui_state_reg <= wave_timing_pkg::UI_IDLE;
            count_reg <= '0;
            int_strobe_reg <= 1'b0;
        end else begin
            int_strobe_reg <= 1'b0;
            unique case (ui_state_reg)
                wave_timing_pkg::UI_IDLE: begin
                    if (!ui_stop && trig_fire && !ctrl_reg.ext_strobe) begin
                        ui_state_reg <= wave_timing_pkg::UI_RUN;
                        count_reg <= load_reg[wave_timing_pkg::LOAD_W-1:0];
                    end
                end
                wave_timing_pkg::UI_RUN: begin
                    if (ui_stop) begin
                        ui_state_reg <= wave_timing_pkg::UI_IDLE;
                    end else if (ui_tick) begin
                        if (count_reg == '0) begin
                            count_reg <= load_reg[wave_timing_pkg::LOAD_W-1:0];
                            int_strobe_reg <= 1'b1;
                        end else begin
                            count_reg <= count_reg - 1'b1;
                        end
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // Strobe delivery and output pulses

    logic strobe_src;
    logic deliver;
    logic strobe_n_reg;
    logic [wave_timing_pkg::PULSE_CNT_W-1:0] strobe_cnt_reg;
    logic trig_out_reg;
    logic [wave_timing_pkg::PULSE_CNT_W-1:0] trig_cnt_reg;
    logic trig_oe_reg;
    logic strobe_oe_reg;

    assign strobe_src = ctrl_reg.ext_strobe ? ext_strobe_edge : int_strobe_reg;
    // Strobes inside a running output pulse are dropped to keep its width exact
    assign deliver = strobe_src & ctrl_reg.posted & ~ctrl_reg.sw_gate
        & gen_active_reg & strobe_n_reg & (strobe_cnt_reg == '0);

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            strobe_n_reg <= 1'b1;
            strobe_cnt_reg <= '0;
            dac_update_o <= 1'b0;
        end else begin
            dac_update_o <= deliver;
            if (deliver) begin
                strobe_n_reg <= 1'b0;
                strobe_cnt_reg <=
                    wave_timing_pkg::PULSE_CNT_W'(wave_timing_pkg::STROBE_PULSE_CYC - 1);
            end else if (strobe_cnt_reg != '0) begin
                strobe_cnt_reg <= strobe_cnt_reg - 1'b1;
            end else begin
                strobe_n_reg <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_out_reg <= 1'b0;
            trig_cnt_reg <= '0;
        end else if (trig_fire) begin
            trig_out_reg <= 1'b1;
            trig_cnt_reg <=
                wave_timing_pkg::PULSE_CNT_W'(wave_timing_pkg::TRIG_PULSE_CYC - 1);
        end else if (trig_cnt_reg != '0) begin
            trig_cnt_reg <= trig_cnt_reg - 1'b1;
        end else begin
            trig_out_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            trig_oe_reg <= 1'b0;
            strobe_oe_reg <= 1'b0;
        end else begin
            trig_oe_reg <= ctrl_reg.trig_oe;
            strobe_oe_reg <= ctrl_reg.strobe_oe;
        end
    end

    assign trig_pin_o = trig_out_reg;
    assign trig_pin_oe_o = trig_oe_reg;
    assign strobe_pin_o = strobe_n_reg;
    assign strobe_pin_oe_o = strobe_oe_reg;

    ////////////////////////////////////////////////////////////////////////////
    // Assertions

    sequence s_strobe_low6;
        !strobe_n_reg [*6] ##1 strobe_n_reg;
    endsequence

    sequence s_trig_high1;
        trig_out_reg ##1 !trig_out_reg;
    endsequence

    a_trig_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
        ($rose(trig_out_reg) && !trig_fire) |-> s_trig_high1)
        else $error("trigger output pulse width wrong");

    a_trig_mirror: assert property (@(posedge clk_i) disable iff (rst_i)
        trig_fire |=> (trig_out_reg && wave_start_o && gen_active_reg))
        else $error("trigger output did not follow trigger");

    a_strobe_pulse_width: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(strobe_n_reg) |-> s_strobe_low6)
        else $error("strobe output pulse width wrong");

    a_dac_update_edge: assert property (@(posedge clk_i) disable iff (rst_i)
        dac_update_o == $fell(strobe_n_reg))
        else $error("converter update not at strobe leading edge");

    a_strobe_gating: assert property (@(posedge clk_i) disable iff (rst_i)
        $fell(strobe_n_reg) |-> $past(ctrl_reg.posted && !ctrl_reg.sw_gate && strobe_src))
        else $error("strobe delivered without posted mode or while gated");

    a_pins_after_reset: assert property (@(posedge clk_i) disable iff (rst_i)
        $past(rst_i) |-> (!trig_pin_oe_o && !strobe_pin_oe_o))
        else $error("output pin driven right after reset");

    a_counter_start: assert property (@(posedge clk_i) disable iff (rst_i)
        (ui_state_reg == wave_timing_pkg::UI_IDLE && trig_fire && !ui_stop
            && !ctrl_reg.ext_strobe)
        |=> (ui_state_reg == wave_timing_pkg::UI_RUN
            && count_reg == $past(load_reg[wave_timing_pkg::LOAD_W-1:0])))
        else $error("interval counter did not start on trigger");

    a_counter_stop: assert property (@(posedge clk_i) disable iff (rst_i)
        ui_stop |=> (ui_state_reg == wave_timing_pkg::UI_IDLE) && !gen_active_reg
            || $past(trig_fire))
        else $error("interval counter did not stop");

    a_counter_reload: assert property (@(posedge clk_i) disable iff (rst_i)
        (ui_state_reg == wave_timing_pkg::UI_RUN && !ui_stop && ui_tick && count_reg == '0)
        |=> int_strobe_reg ##0 count_reg == $past(load_reg[wave_timing_pkg::LOAD_W-1:0]))
        else $error("counter expiry gave no strobe");

    a_slow_tick_spacing: assert property (@(posedge clk_i) disable iff (rst_i)
        slow_tick |=> !slow_tick [*8])
        else $error("slow timebase ticks too close");

endmodule : waveform_update_timing

// file: design/wave_timing_pkg.sv
package wave_timing_pkg;

    // Clock and timebases
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 1_000_000_000 / CLK_HZ;
    localparam int SLOW_TB_HZ = 100_000;
    localparam int SLOW_TB_DIV = CLK_HZ / SLOW_TB_HZ;
    localparam int SLOW_DIV_W = 8;

    // Output pulse widths: least time rounded up to whole cycles
    localparam int TRIG_PULSE_MIN_NS = 50;
    localparam int TRIG_PULSE_MAX_NS = 100;
    localparam int TRIG_PULSE_CYC = (TRIG_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int STROBE_PULSE_MIN_NS = 300;
    localparam int STROBE_PULSE_MAX_NS = 350;
    localparam int STROBE_PULSE_CYC =
        (STROBE_PULSE_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int PULSE_CNT_W = 4;

    // Register byte addresses
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_CTRL = 8'h00;
    localparam logic [7:0] ADDR_SEL = 8'h04;
    localparam logic [7:0] ADDR_LOAD = 8'h08;
    localparam logic [7:0] ADDR_CMD = 8'h0C;
    localparam logic [7:0] ADDR_STATUS = 8'h10;

    // Field layouts and reset values
    localparam logic [31:0] CTRL_MASK = 32'h0000_07FF;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
    localparam logic [31:0] SEL_MASK = 32'h0000_0FFF;
    localparam logic [31:0] SEL_RESET = 32'h0000_0000;
    localparam int SEL_FIELD_W = 4;
    localparam int SEL_TRIG_LSB = 0;
    localparam int SEL_STROBE_LSB = 4;
    localparam int SEL_UICLK_LSB = 8;
    localparam int LOAD_W = 16;
    localparam logic [31:0] LOAD_MASK = 32'h0000_FFFF;
    localparam logic [31:0] LOAD_RESET = 32'h0000_0000;
    localparam int CMD_STOP_BIT = 0;
    localparam int CMD_SWTRIG_BIT = 1;

    typedef enum logic [1:0] {
        UICLK_FAST = 2'h0,
        UICLK_SLOW = 2'h1,
        UICLK_EXT = 2'h2
    } ui_clk_src_t;

    typedef struct packed {
        logic [20:0] reserved;
        logic uiclk_active_low;
        ui_clk_src_t ui_src;
        logic strobe_oe;
        logic trig_oe;
        logic sw_gate;
        logic posted;
        logic ext_strobe;
        logic strobe_falling;
        logic trig_falling;
        logic arm;
    } ctrl_t;

    typedef struct packed {
        logic [15:0] count;
        logic [13:0] reserved;
        logic counting;
        logic generating;
    } status_t;

    typedef enum logic [1:0] {
        UI_IDLE = 2'b01,
        UI_RUN = 2'b10
    } ui_state_t;

endpackage : wave_timing_pkg

// file: tb/pfi_source_model.sv
`timescale 1ns/1ps
module pfi_source_model #(
    parameter int PINS = 10
) (
    // Clock
    input wire logic clk_i,
    // Pins toward the block
    output logic [PINS-1:0] pfi_o
);
    initial pfi_o = '0;

    // One level change just after an edge, then a quiet spell before the next
    task automatic flip(input int idx, input int hold);
        @(posedge clk_i);
        pfi_o[idx] <= ~pfi_o[idx];
        repeat (hold) @(posedge clk_i);
    endtask : flip

    // Interval clock burst: 100 ns high, 100 ns low; rests low between bursts
    task automatic burst(input int idx, input int n);
        repeat (n) begin
            @(posedge clk_i);
            pfi_o[idx] <= 1'h1;
            repeat (2) @(posedge clk_i);
            pfi_o[idx] <= 1'h0;
            @(posedge clk_i);
        end
    endtask : burst
endmodule : pfi_source_model

// file: tb/waveform_update_timing_tb.sv
`timescale 1ns/1ps
module waveform_update_timing_tb;
    logic clk = 1'h0;
    logic rst = 1'h1;
    logic wb_cyc = 1'h0;
    logic wb_stb = 1'h0;
    logic wb_we = 1'h0;
    logic [7:0] wb_adr = 8'h00;
    logic [3:0] wb_sel = 4'h0;
    logic [31:0] wb_dat = 32'h0;
    logic buf_done = 1'h0;
    logic [31:0] wb_dat_o;
    logic wb_ack_o;
    logic trig_pin_o;
    logic trig_pin_oe_o;
    logic strobe_pin_o;
    logic strobe_pin_oe_o;
    logic wave_start_o;
    logic dac_update_o;
    logic [9:0] pfi;
    int fail_count = 0;
    int samples_checked = 0;
    int cyc_no = 0, upd_n = 0, start_n = 0, trig_n = 0, gap = 0, last_upd = 0;
    int low_len = 0, low_seen = 0, hi_len = 0, hi_seen = 0, sync_bad = 0, u0 = 0;

    waveform_update_timing #(.PFI_COUNT(10)) i_dut (
        .clk_i(clk), .rst_i(rst), .wb_cyc_i(wb_cyc), .wb_stb_i(wb_stb),
        .wb_we_i(wb_we), .wb_adr_i(wb_adr), .wb_sel_i(wb_sel), .wb_dat_i(wb_dat),
        .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pfi_i(pfi),
        .buffer_done_i(buf_done), .trig_pin_o(trig_pin_o),
        .trig_pin_oe_o(trig_pin_oe_o), .strobe_pin_o(strobe_pin_o),
        .strobe_pin_oe_o(strobe_pin_oe_o), .wave_start_o(wave_start_o),
        .dac_update_o(dac_update_o)
    );
    pfi_source_model #(.PINS(10)) i_src (.clk_i(clk), .pfi_o(pfi));

    initial forever #25 clk = ~clk;

    ////////////////////////////////////////////////////////////////////////////
    // Pulse monitor: counts and widths, never reset, read as deltas
    always @(posedge clk) begin
        cyc_no <= cyc_no + 1;
        if (dac_update_o === 1'h1) begin
            upd_n <= upd_n + 1;
            gap <= cyc_no - last_upd;
            last_upd <= cyc_no;
            if (strobe_pin_o !== 1'h0) sync_bad <= sync_bad + 1;
        end
        if (wave_start_o === 1'h1) start_n <= start_n + 1;
        if (trig_pin_o === 1'h1 && hi_len == 0) trig_n <= trig_n + 1;
        low_len <= (strobe_pin_o === 1'h0) ? low_len + 1 : 0;
        if (strobe_pin_o === 1'h1 && low_len != 0) low_seen <= low_len;
        hi_len <= (trig_pin_o === 1'h1) ? hi_len + 1 : 0;
        if (trig_pin_o !== 1'h1 && hi_len != 0) hi_seen <= hi_len;
    end

    ////////////////////////////////////////////////////////////////////////////
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            fail_count++;
            $display("wrong value %s expected %0h seen %0h", what, exp, got);
        end
    endtask : check

    // Classic cycle: hold everything until ack is sampled high
    task automatic wb_io(input logic we, input logic [7:0] adr, input logic [31:0] wd,
                         output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge clk);
        wb_cyc <= 1'h1;
        wb_stb <= 1'h1;
        wb_we <= we;
        wb_adr <= adr;
        wb_dat <= wd;
        wb_sel <= 4'hF;
        do begin
            @(posedge clk);
            n++;
        end while (wb_ack_o !== 1'h1 && n < 16);
        rd = wb_dat_o;
        check("ack", 32'h1, 32'(wb_ack_o));
        wb_cyc <= 1'h0;
        wb_stb <= 1'h0;
        wb_we <= 1'h0;
    endtask : wb_io

    task automatic wr(input logic [7:0] adr, input logic [31:0] d);
        logic [31:0] r;
        wb_io(1'h1, adr, d, r);
    endtask : wr

    task automatic rdc(input logic [7:0] adr, input logic [31:0] exp);
        logic [31:0] r;
        wb_io(1'h0, adr, 32'h0, r);
        check("read data", exp, r);
    endtask : rdc

    // Stop, then one full pulse on a pin; both edges reach the trigger input
    task automatic fire(input int pin, input int exp);
        int s0, t0;
        wr(8'h0C, 32'h1);
        s0 = start_n;
        t0 = trig_n;
        i_src.flip(pin, 3);
        i_src.flip(pin, 8);
        check("starts", 32'(exp), 32'(start_n - s0));
        check("trigger pulses", 32'(exp), 32'(trig_n - t0));
    endtask : fire

    task automatic updates(input int wait_n, input int exp);
        repeat (wait_n) @(posedge clk);
        check("updates", 32'(exp), 32'(upd_n - u0));
    endtask : updates

    task automatic no_update(input logic [31:0] ctrl);
        wr(8'h0C, 32'h1);
        wr(8'h00, ctrl);
        u0 = upd_n;
        fire(3, 1);
        updates(40, 0);
    endtask : no_update

    ////////////////////////////////////////////////////////////////////////////
    task automatic t_reset;
        check("trig oe", 32'h0, 32'(trig_pin_oe_o));
        check("strobe oe", 32'h0, 32'(strobe_pin_oe_o));
        check("strobe idle", 32'h1, 32'(strobe_pin_o));
        rdc(8'h00, 32'h0);
        rdc(8'h20, 32'h0);
        wr(8'h08, 32'hFFFF_1234);
        rdc(8'h08, 32'h0000_1234);
    endtask : t_reset

    task automatic t_trigger;
        int t0;
        wr(8'h04, 32'h3);
        wr(8'h00, 32'h41);
        repeat (2) @(posedge clk);
        check("trig oe", 32'h1, 32'(trig_pin_oe_o));
        fire(3, 1);
        check("trig width", 32'h1, 32'(hi_seen));
        wr(8'h00, 32'h43);
        wr(8'h0C, 32'h1);
        u0 = start_n;
        i_src.flip(3, 8);
        check("rise ignored", 32'h0, 32'(start_n - u0));
        i_src.flip(3, 8);
        check("fall taken", 32'h1, 32'(start_n - u0));
        wr(8'h04, 32'h8);
        wr(8'h00, 32'h41);
        fire(8, 1);
        // Software trigger must start generation and show on the trigger pin
        u0 = start_n;
        t0 = trig_n;
        wr(8'h0C, 32'h2);
        repeat (2) @(posedge clk);
        check("sw trigger starts", 32'h1, 32'(start_n - u0));
        check("sw trigger pulse", 32'h1, 32'(trig_n - t0));
        wr(8'h00, 32'h40);
        fire(8, 0);
        u0 = start_n;
        wr(8'h0C, 32'h2);
        repeat (2) @(posedge clk);
        check("sw trigger disarmed", 32'h0, 32'(start_n - u0));
    endtask : t_trigger

    task automatic t_internal;
        wr(8'h04, 32'h3);
        wr(8'h08, 32'h9);
        wr(8'h00, 32'hD1);
        u0 = upd_n;
        fire(3, 1);
        repeat (60) @(posedge clk);
        check("update gap", 32'hA, 32'(gap));
        check("many updates", 32'h1, 32'(upd_n - u0 > 4));
        check("strobe low", 32'h6, 32'(low_seen));
        check("update sync", 32'h0, 32'(sync_bad));
        check("strobe oe", 32'h1, 32'(strobe_pin_oe_o));
        wr(8'h0C, 32'h1);
        repeat (8) @(posedge clk);
        u0 = upd_n;
        updates(40, 0);
        no_update(32'hF1);
        no_update(32'hC1);
        wr(8'h00, 32'hD1);
        fire(3, 1);
        @(posedge clk) buf_done <= 1'h1;
        @(posedge clk) buf_done <= 1'h0;
        repeat (8) @(posedge clk);
        u0 = upd_n;
        updates(40, 0);
        wr(8'h08, 32'h0);
        wr(8'h00, 32'h1D1);
        fire(3, 1);
        repeat (450) @(posedge clk);
        check("slow gap", 32'hC8, 32'(gap));
        // Reload of zero keeps the count field at zero, so status is exact
        rdc(8'h10, 32'h0000_0003);
        wr(8'h0C, 32'h1);
        rdc(8'h10, 32'h0000_0000);
    endtask : t_internal

    task automatic t_ext_strobe;
        wr(8'h04, 32'h53);
        wr(8'h00, 32'hDD);
        fire(3, 1);
        u0 = upd_n;
        i_src.flip(5, 14);
        check("rise ignored", 32'h0, 32'(upd_n - u0));
        i_src.flip(5, 14);
        check("fall updates", 32'h1, 32'(upd_n - u0));
        check("strobe low", 32'h6, 32'(low_seen));
        check("update sync", 32'h0, 32'(sync_bad));
        wr(8'h00, 32'hFD);
        u0 = upd_n;
        i_src.flip(5, 14);
        i_src.flip(5, 14);
        updates(2, 0);
    endtask : t_ext_strobe

    // Active-high then active-low interval clock on pin 7
    task automatic t_ext_clock;
        wr(8'h04, 32'h703);
        wr(8'h08, 32'h1);
        for (int k = 0; k < 2; k++) begin
            wr(8'h00, k ? 32'h6D1 : 32'h2D1);
            fire(3, 1);
            u0 = upd_n;
            updates(30, 0);
            i_src.burst(7, 8);
            updates(16, 4);
            check("ext gap", 32'h8, 32'(gap));
        end
    endtask : t_ext_clock

    ////////////////////////////////////////////////////////////////////////////
    task automatic stop_test;
        $display("checks %0d mismatches %0d", samples_checked, fail_count);
        if (fail_count == 0 && samples_checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask : stop_test

    initial begin
        #(30000 * 50);
        fail_count++;
        $display("watchdog expired");
        stop_test;
    end

    initial begin
        repeat (12) @(posedge clk);
        rst <= 1'h0;
        t_reset;
        t_trigger;
        t_internal;
        t_ext_strobe;
        t_ext_clock;
        stop_test;
    end
endmodule : waveform_update_timing_tb
